// [core/i2css_pkg.sv]
// What this block does
// (RULE_01) Status bit 5 reads 1 while the bus is busy, 0 when idle.
// (RULE_02) Busy flag sets on SDA falling while SCL is high.
// (RULE_03) Busy flag clears on SDA rising while SCL is high.
// (RULE_04) Control bit 4 selects slave role: 0 receiver, 1 transmitter.
// (RULE_05) As receiver, drive the ninth-clock acknowledge from the ack-out bit.
// (RULE_06) Eighth bit after START is captured as the read-request flag.
// (RULE_07) Wake-up pulse on own address match only when wake-up enable is set.
// (RULE_08) As transmitter, sample SDA on ninth clock into the ack-in flag.
// (RULE_09) Keep sending while ack-in is 0; release SDA once it is 1.
// (RULE_10) One 8-bit data buffer holds transmitted and received bytes.
// (RULE_11) Software loads the buffer before sending; received byte reads back there.
// (RULE_12) Own 7-bit address sits in bits 7..1 of the address register.
// (RULE_13) Selected only when the sent address equals the own address.
// (RULE_14) Address register bit 0 is unused but reads back as written.
// (RULE_15) Address register shares its location with the second SPI control register.
package i2css_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_DATA_BUFFER = 4'h4;
    localparam logic [3:0] ADDR_OWN_ADDRESS = 4'h8;
    // --------------------------------------------------------------
    // Status/control field positions
    // --------------------------------------------------------------
    localparam int BIT_COMPLETE = 7;
    localparam int BIT_ADDR_MATCH = 6;
    localparam int BIT_BUS_BUSY = 5;
    localparam int BIT_TX_ROLE = 4;
    localparam int BIT_ACK_OUT = 3;
    localparam int BIT_READ_REQ = 2;
    localparam int BIT_WAKE_EN = 1;
    localparam int BIT_ACK_IN = 0;
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h81;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    // Bus engine states
    typedef enum logic [2:0] {
        IDLE = 3'b000,
        ADDR = 3'b001,
        ADDR_ACK = 3'b010,
        RX = 3'b011,
        TX = 3'b100,
        DATA_ACK = 3'b101,
        IGNORE = 3'b110
    } i2css_state_type;
endpackage : i2css_pkg

// [core/i2css_slave.sv]
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module i2css_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // I2C pins, open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // System
    output logic wakeup
);
    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclPrev;
    logic sdaPrev;
    // Two flops per pin, then one history flop for edges.
    // Pin edges reach the engine about three clocks late, so each SCL
    // level must last several clocks; no clock stretching is offered.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end
    wire logic scl = sclSync[1];
    wire logic sda = sdaSync[1];
    wire logic sclRise = scl && !sclPrev;
    wire logic sclFall = !scl && sclPrev;
    // (RULE_02) Start detect
    wire logic startSeen = scl && sclPrev && sdaPrev && !sda;
    // (RULE_03) Stop detect
    wire logic stopSeen = scl && sclPrev && !sdaPrev && sda;

    // --------------------------------------------------------------
    // Registers and bus decode
    // --------------------------------------------------------------
    logic busBusy;
    logic txRole;
    logic ackOut;
    logic readReq;
    logic wakeEn;
    logic ackIn;
    logic addrMatch;
    logic complete;
    logic [7:0] dataBuffer;
    logic [7:0] ownAddress;
    logic [7:0] shiftReg;
    logic [3:0] bitCount;
    i2css_pkg::i2css_state_type state;
    i2css_pkg::i2css_state_type next_state;

    // Zero wait states: pready is tied high and every access takes two
    // cycles; a read latches its byte in the setup cycle
    wire logic access = psel && penable;
    wire logic wrEn = access && pwrite;
    wire logic selStatus = paddr == i2css_pkg::ADDR_STATUS_CONTROL;
    wire logic selData = paddr == i2css_pkg::ADDR_DATA_BUFFER;
    // (RULE_15) One location for own address and SPI second control
    wire logic selAddr = paddr == i2css_pkg::ADDR_OWN_ADDRESS;
    wire logic mapped = selStatus || selData || selAddr;
    wire logic [7:0] statusValue = {complete, addrMatch, busBusy, txRole,
                                    ackOut, readReq, wakeEn, ackIn};
    wire logic [7:0] readByte = selStatus ? statusValue :
                                selData ? dataBuffer :
                                selAddr ? ownAddress : 8'h00;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read data register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, readByte};
        end
    end

    // (RULE_04) Software writable control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txRole <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_TX_ROLE];
            ackOut <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_ACK_OUT];
            wakeEn <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_WAKE_EN];
        end else if (wrEn && selStatus) begin
            txRole <= pwdata[i2css_pkg::BIT_TX_ROLE];
            ackOut <= pwdata[i2css_pkg::BIT_ACK_OUT];
            wakeEn <= pwdata[i2css_pkg::BIT_WAKE_EN];
        end
    end

    // (RULE_12) Own address, bit 0 kept as plain storage
    // (RULE_14) Spare bit readable and writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ownAddress <= i2css_pkg::OWN_ADDRESS_RESET;
        end else if (wrEn && selAddr) begin
            ownAddress <= pwdata[7:0];
        end
    end

    // --------------------------------------------------------------
    // Bus engine
    // --------------------------------------------------------------
    wire logic byteDone = sclRise && bitCount == i2css_pkg::LAST_DATA_BIT;
    wire logic ninthRise = sclRise && bitCount == i2css_pkg::ACK_BIT;
    wire logic [7:0] nextShift = {shiftReg[6:0], sda};
    // (RULE_13) Address compare on the seven address bits
    wire logic isMe = shiftReg[6:0] == ownAddress[7:1];

    // Next state.
    // START and STOP override every state, so a frame that the master
    // cuts short always brings the engine back to a known point.
    always_comb begin
        next_state = state;
        case (state)
            i2css_pkg::IDLE: next_state = i2css_pkg::IDLE;
            i2css_pkg::ADDR: begin
                if (byteDone) begin
                    next_state = isMe ? i2css_pkg::ADDR_ACK : i2css_pkg::IGNORE;
                end
            end
            i2css_pkg::ADDR_ACK: begin
                if (sclFall && bitCount == i2css_pkg::ACK_BIT) begin
                    next_state = txRole ? i2css_pkg::TX : i2css_pkg::RX;
                end
            end
            i2css_pkg::RX: begin
                if (byteDone) begin
                    next_state = i2css_pkg::DATA_ACK;
                end
            end
            i2css_pkg::TX: begin
                if (byteDone) begin
                    next_state = i2css_pkg::DATA_ACK;
                end
            end
            i2css_pkg::DATA_ACK: begin
                if (sclFall && bitCount == i2css_pkg::ACK_BIT) begin
                    // (RULE_09) Stop sending after a missing acknowledge
                    if (txRole && ackIn) begin
                        next_state = i2css_pkg::IGNORE;
                    end else begin
                        next_state = txRole ? i2css_pkg::TX : i2css_pkg::RX;
                    end
                end
            end
            i2css_pkg::IGNORE: next_state = i2css_pkg::IGNORE;
            default: next_state = i2css_pkg::IDLE;
        endcase
        if (stopSeen) begin
            next_state = i2css_pkg::IDLE;
        end
        if (startSeen) begin
            next_state = i2css_pkg::ADDR;
        end
    end

    // State, bit counter and busy flag.
    // The counter runs 0..7 over the data bits and 8 on the acknowledge bit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= i2css_pkg::IDLE;
            bitCount <= 4'h0;
            busBusy <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_BUS_BUSY];
        end else begin
            state <= next_state;
            // The SCL fall that follows START wraps the count to bit 0
            if (startSeen) begin
                bitCount <= i2css_pkg::ACK_BIT;
            end else if (sclFall) begin
                bitCount <= (bitCount == i2css_pkg::ACK_BIT) ? 4'h0 : bitCount + 4'h1;
            end
            // (RULE_01) Busy set by start, cleared by stop
            if (startSeen) begin
                busBusy <= 1'b1;
            end else if (stopSeen) begin
                busBusy <= 1'b0;
            end
        end
    end

    // Shift register samples on SCL rise, loads buffer on TX entry.
    // While sending it moves on once the master has sampled a bit, so
    // the next bit already waits when SCL falls.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftReg <= 8'h00;
        end else if (next_state == i2css_pkg::TX && state != i2css_pkg::TX) begin
            shiftReg <= dataBuffer;
        end else if (sclRise && state == i2css_pkg::TX) begin
            shiftReg <= {shiftReg[6:0], 1'b1};
        end else if (sclRise) begin
            shiftReg <= nextShift;
        end
    end

    // (RULE_10) Shared data buffer
    // (RULE_11) Received byte lands here; software write wins otherwise.
    // A received byte beats a software write in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataBuffer <= i2css_pkg::DATA_RESET;
        end else if (state == i2css_pkg::RX && byteDone) begin
            dataBuffer <= nextShift;
        end else if (wrEn && selData) begin
            dataBuffer <= pwdata[7:0];
        end
    end

    // Status flags set by the bus engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readReq <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_READ_REQ];
            ackIn <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_ACK_IN];
            addrMatch <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_ADDR_MATCH];
            complete <= i2css_pkg::STATUS_CONTROL_RESET[i2css_pkg::BIT_COMPLETE];
            wakeup <= 1'b0;
        end else begin
            wakeup <= 1'b0;
            // (RULE_06) Eighth bit is the read request
            if (state == i2css_pkg::ADDR && byteDone) begin
                readReq <= sda;
                addrMatch <= isMe;
                // (RULE_07) Wake on match when enabled
                wakeup <= isMe && wakeEn;
            end
            // (RULE_08) Ninth-clock acknowledge sample
            if (state == i2css_pkg::DATA_ACK && txRole && ninthRise) begin
                ackIn <= sda;
            end
            if ((state == i2css_pkg::RX || state == i2css_pkg::TX) && byteDone) begin
                complete <= 1'b1;
                addrMatch <= 1'b0;
            end else if (startSeen) begin
                complete <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // SDA drive
    // --------------------------------------------------------------
    logic next_sdaOe;
    // First bit of a byte comes straight from the buffer, later ones
    // from the shift register
    wire logic txBit = (state == i2css_pkg::TX) ? shiftReg[7] : dataBuffer[7];
    // Drive is chosen from the next state, so a new bit is on the line
    // one clock after the SCL fall is seen, before the master raises SCL
    always_comb begin
        next_sdaOe = 1'b0;
        case (next_state)
            i2css_pkg::ADDR_ACK: next_sdaOe = 1'b1;
            // (RULE_05) Receiver acknowledge from ack-out bit
            i2css_pkg::DATA_ACK: next_sdaOe = !txRole && !ackOut;
            // (RULE_09) Transmit zeros only, release on ones
            i2css_pkg::TX: next_sdaOe = !txBit;
            default: next_sdaOe = 1'b0;
        endcase
    end
    assign sdaOut = 1'b0;
    // Drive register updates while SCL is low, or in IDLE or IGNORE; a change under a
    // high SCL would look like START or STOP to every device
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaOe <= 1'b0;
        end else if (!scl || state == i2css_pkg::IDLE || state == i2css_pkg::IGNORE) begin
            sdaOe <= next_sdaOe;
        end
    end
endmodule : i2css_slave
`default_nettype wire

// [dv/i2css_slave_props.sv]
`timescale 1ns/1ns
`default_nettype none
module i2css_slave_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Bus pins and system
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic wakeup
);
    logic busyTrk;
    logic sdaPrev;
    logic unmapped;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign unmapped = !(paddr inside {4'h0, 4'h4, 4'h8});
    // Frame tracker built from the raw pin levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyTrk <= 1'b0;
            sdaPrev <= 1'b1;
        end else begin
            sdaPrev <= sdaIn;
            if (sclIn && sdaPrev != sdaIn) begin
                busyTrk <= sdaPrev;
            end
        end
    end
    sequence apbAccess;
        psel && penable;
    endsequence
    sequence unmappedRead;
        psel && penable && !pwrite && unmapped;
    endsequence
    a_ready_access: assert property (apbAccess |-> pready)
        else $error("pready low in access phase");
    a_err_decode: assert property (apbAccess |-> pslverr == unmapped)
        else $error("pslverr does not follow the address decode");
    a_unmapped_zero: assert property (unmappedRead |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_open_drain: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    a_wake_pulse: assert property (wakeup |=> !wakeup)
        else $error("wake pulse longer than one cycle");
    a_wake_ack: assert property (wakeup |-> ##[0:40] sdaOe)
        else $error("address match without acknowledge");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed without a read");
    a_oe_in_frame: assert property (sdaOe |-> busyTrk)
        else $error("data line pulled outside a frame");
endmodule : i2css_slave_props
bind i2css_slave i2css_slave_props u_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .sclIn, .sdaIn, .sdaOut, .sdaOe, .wakeup);
`default_nettype wire

// [dv/i2css_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
module i2css_master_model (
    // Clock
    input wire logic clk,
    // Slave pull-down
    input wire logic sdaOe,
    // Bus lines
    output logic scl,
    output logic sda
);
    logic sclDrv = 1'b1;
    logic sdaDrv = 1'b1;
    logic dummy;
    // Wired-AND with pull-up, a released line reads high
    assign scl = sclDrv;
    assign sda = sdaDrv & ~sdaOe;
    // One quarter of a 320 ns bit
    task automatic step(input logic c, input logic d);
        repeat (2) @(posedge clk);
        sclDrv <= c;
        sdaDrv <= d;
    endtask : step
    task automatic start();
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        step(1'b0, sdaDrv);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
    // Data changes only while the clock is low
    task automatic xfer(input logic d, output logic s);
        step(1'b0, sdaDrv);
        step(1'b0, d);
        step(1'b1, d);
        repeat (2) @(posedge clk);
        s = sda;
    endtask : xfer
    task automatic writeByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xfer(b[i], dummy);
        end
        xfer(1'b1, ack);
    endtask : writeByte
    task automatic readByte(input logic nack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, b[i]);
        end
        xfer(nack, dummy);
    endtask : readByte
endmodule : i2css_master_model
`default_nettype wire

// [dv/i2c_slave_status_data_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_status_data_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [3:0] paddr = 4'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sdaOut, sdaOe, wakeup, sclIn, sdaIn, ack, err;
    logic [7:0] rd, got;
    int n_fail = 0;
    int comparisons = 0;
    int wakes = 0;
    i2css_slave DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sclIn, .sdaIn, .sdaOut, .sdaOe, .wakeup);
    i2css_master_model m (.clk, .sdaOe, .scl(sclIn), .sda(sdaIn));
    // Clock and wake pulse count
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wakeup === 1'b1) begin
            wakes++;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int i;
        repeat (5) @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t no pready", $time);
            results();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic regsAccess();
        apb(1'b0, 4'h0, 8'h00);
        chk(rd, 8'h81);
        apb(1'b1, 4'h0, 8'hff);
        apb(1'b0, 4'h0, 8'h00);
        chk(rd, 8'h9b);
        apb(1'b1, 4'h8, 8'ha5);
        apb(1'b0, 4'h8, 8'h00);
        chk(rd, 8'ha5);
        apb(1'b0, 4'hc, 8'h00);
        chk({7'h0, err}, 8'h01);
        chk(rd, 8'h00);
    endtask : regsAccess
    task automatic slaveReceive();
        apb(1'b1, 4'h0, 8'h00);
        m.start();
        apb(1'b0, 4'h0, 8'h00);
        chk(rd & 8'h20, 8'h20);
        m.writeByte(8'ha4, ack);
        chk({7'h0, ack}, 8'h00);
        apb(1'b0, 4'h0, 8'h00);
        chk(rd & 8'h04, 8'h00);
        m.writeByte(8'h3c, ack);
        chk({7'h0, ack}, 8'h00);
        apb(1'b0, 4'h4, 8'h00);
        chk(rd, 8'h3c);
        apb(1'b1, 4'h0, 8'h08);
        m.writeByte(8'hc3, ack);
        chk({7'h0, ack}, 8'h01);
        apb(1'b0, 4'h4, 8'h00);
        chk(rd, 8'hc3);
        m.stop();
        apb(1'b0, 4'h0, 8'h00);
        chk(rd & 8'h20, 8'h00);
        chk(8'(wakes), 8'h00);
        m.start();
        m.writeByte(8'ha6, ack);
        chk({7'h0, ack}, 8'h01);
        m.stop();
    endtask : slaveReceive
    task automatic slaveTransmit();
        apb(1'b1, 4'h4, 8'h96);
        apb(1'b1, 4'h0, 8'h12);
        m.start();
        m.writeByte(8'ha5, ack);
        chk({7'h0, ack}, 8'h00);
        chk(8'(wakes), 8'h01);
        apb(1'b0, 4'h0, 8'h00);
        chk(rd & 8'h04, 8'h04);
        m.readByte(1'b0, got);
        chk(got, 8'h96);
        apb(1'b1, 4'h4, 8'h5a);
        apb(1'b0, 4'h0, 8'h00);
        chk(rd & 8'h01, 8'h00);
        m.readByte(1'b1, got);
        chk(got, 8'h5a);
        apb(1'b0, 4'h0, 8'h00);
        chk(rd & 8'h01, 8'h01);
        m.step(1'b0, 1'b1);
        repeat (6) @(posedge clk);
        chk({7'h0, sdaOe}, 8'h00);
        m.stop();
    endtask : slaveTransmit
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        regsAccess();
        slaveReceive();
        slaveTransmit();
        results();
    end
endmodule : i2c_slave_status_data_bench
`default_nettype wire
